// File: common/sbs_pkg.sv
// Constants and types of the servo brake/stop sequencer.
// Assumes a 125 MHz core clock and a 32-bit AHB-Lite register bus.
package sbs_pkg;
	// ==============================================================
	// Clock and time base
	localparam int unsigned CLK_HZ       = 125000000;
	localparam int unsigned TICK_MS      = 1;
	localparam int unsigned TICK_CYC     = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned UNIT10_TICKS = 10;

	// ==============================================================
	// Register byte offsets
	localparam logic [7:0] OFS_STOP_CFG   = 8'h00;
	localparam logic [7:0] OFS_BRK_DLY    = 8'h04;
	localparam logic [7:0] OFS_BRK_SPD    = 8'h08;
	localparam logic [7:0] OFS_BRK_WAIT   = 8'h0C;
	localparam logic [7:0] OFS_DIP_HOLD   = 8'h10;
	localparam logic [7:0] OFS_STATUS     = 8'h14;
	localparam logic [7:0] OFS_IRQ_STAT   = 8'h18;
	localparam logic [7:0] OFS_IRQ_CLR    = 8'h1C;
	localparam logic [7:0] OFS_IRQ_EN     = 8'h20;
	localparam logic [7:0] OFS_CTRL       = 8'h24;

	// ==============================================================
	// Field positions
	localparam int unsigned STOP_SEL_LSB  = 0;
	localparam int unsigned ALM_SEL_BIT   = 4;
	localparam int unsigned CTRL_RESTART  = 0;
	localparam int unsigned IRQ_W         = 4;
	localparam int unsigned IRQ_ALARM     = 0;
	localparam int unsigned IRQ_BRAKE     = 1;
	localparam int unsigned IRQ_DIP_OFF   = 2;
	localparam int unsigned IRQ_RESTORE   = 3;

	// ==============================================================
	// Reset values and limits
	localparam logic [1:0]  RST_STOP_SEL  = 2'h0;
	localparam logic        RST_ALM_SEL   = 1'b0;
	localparam logic [15:0] RST_BRK_DLY   = 16'h000A;
	localparam logic [15:0] MAX_BRK_DLY   = 16'h0032;
	localparam logic [15:0] RST_BRK_SPD   = 16'h0064;
	localparam logic [15:0] MAX_BRK_SPD   = 16'h2710;
	localparam logic [15:0] RST_BRK_WAIT  = 16'h0032;
	localparam logic [15:0] MIN_BRK_WAIT  = 16'h000A;
	localparam logic [15:0] MAX_BRK_WAIT  = 16'h0064;
	localparam logic [15:0] RST_DIP_HOLD  = 16'h0014;
	localparam logic [15:0] MIN_DIP_HOLD  = 16'h0014;
	localparam logic [15:0] MAX_DIP_HOLD  = 16'hC350;

	// ==============================================================
	// Stop methods and sequencer states
	localparam logic [1:0] STOP_DB_HOLD  = 2'h0;
	localparam logic [1:0] STOP_DB_COAST = 2'h1;
	localparam logic [1:0] STOP_COAST    = 2'h2;

	typedef enum logic [2:0] {
		ST_OFF    = 3'b000,
		ST_RUN    = 3'b001,
		ST_DELAY  = 3'b010,
		ST_DIP    = 3'b011,
		ST_DIPOFF = 3'b100,
		ST_ZSTOP  = 3'b101,
		ST_WAITB  = 3'b110,
		ST_HALT   = 3'b111
	} sbs_state_e;
endpackage : sbs_pkg

// File: common/sbs_tmr_if.sv
// Carrier between the sequencer and its millisecond timer.
// Assumes one clock; load is a one-cycle pulse.
`timescale 1ns/1ps
interface sbs_tmr_if;
	logic        load;
	logic [15:0] load_ms;
	logic        tick;
	logic        expired;

	modport ctl (output load, output load_ms, output tick, input expired);
	modport tmr (input load, input load_ms, input tick, output expired);
endinterface : sbs_tmr_if

// File: src/sbs_ms_tick.sv
// Millisecond tick generator.
// Assumes a free-running core clock and synchronous reset.
`timescale 1ns/1ps
module sbs_ms_tick #(
	parameter int unsigned CYC = 125000
) (
	input  wire logic core_clk,
	input  wire logic sys_rst,
	output logic      tick
);
	logic [31:0] cnt_q;

	// ==============================================================
	// Divider: one-cycle pulse every CYC cycles
	always_ff @(posedge core_clk) begin
		if (sys_rst || cnt_q == CYC - 1) begin
			cnt_q <= 32'h0000_0000;
		end else begin
			cnt_q <= cnt_q + 32'h0000_0001;
		end
	end

	assign tick = (cnt_q == CYC - 1);
endmodule : sbs_ms_tick

// File: src/sbs_ms_timer.sv
// Millisecond down-counter with load and expired flag.
// Assumes the tick arrives through the carrier interface.
`timescale 1ns/1ps
module sbs_ms_timer (
	input  wire logic core_clk,
	input  wire logic sys_rst,
	sbs_tmr_if.tmr    tif
);
	logic [15:0] cnt_q;
	logic        exp_q;

	// ==============================================================
	// Count ticks down from the loaded value
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cnt_q <= 16'h0000;
			exp_q <= 1'b0;
		end else if (tif.load) begin
			cnt_q <= tif.load_ms;
			exp_q <= (tif.load_ms == 16'h0000);
		end else if (tif.tick && cnt_q != 16'h0000) begin
			cnt_q <= cnt_q - 16'h0001;
			exp_q <= (cnt_q == 16'h0001);
		end
	end

	assign tif.expired = exp_q;
endmodule : sbs_ms_timer

// File: src/sbs_seq.sv
// Servo brake and stop sequencer with AHB-Lite register slave.
// Assumes inputs synchronous to core_clk, one AHB master, speed in rpm.
// Contract
// - Standstill servo-off drops brake release same cycle
// - Power-off delay after servo-off, 10 ms units
// - Alarm removes power without the programmed delay
// - Running alarm starts stop, brake later
// - Brake applies once speed below threshold
// - Brake applies once wait timeout expires
// - Servo-off method: DB hold, DB coast, coast
// - First-class alarm stops like servo-off
// - Second-class alarm: zero-speed stop or servo-off method
// - Supply dip keeps motor powered for hold time
// - Short dip continues, long dip stops power
// - Power returns when main supply is restored
// - Long dip drops ready, enters servo-off
// - Control supply loss acts as normal power-off
// - Brake released only while servo on; code also releases it in ST_ZSTOP and ST_WAITB, and in ST_DIPOFF under overtravel
// - Overtravel keeps brake released
//
// The register addresses and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
module sbs_seq
	import sbs_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        servo_on,
	input  wire logic        first_class_alarm,
	input  wire logic        second_class_alarm,
	input  wire logic        overtravel,
	input  wire logic        main_supply_ok,
	input  wire logic        control_supply_ok,
	input  wire logic [15:0] motor_speed,
	output logic             brake_release_out,
	output logic             motor_power_on,
	output logic             dynamic_brake_stop,
	output logic             zero_speed_stop,
	output logic             servo_ready,
	output logic             irq
);
	// ==============================================================
	// Helpers
	function automatic logic [15:0] clamp(input logic [31:0] v,
			input logic [15:0] lo, input logic [15:0] hi);
		if (v < {16'h0000, lo}) begin
			clamp = lo;
		end else if (v > {16'h0000, hi}) begin
			clamp = hi;
		end else begin
			clamp = v[15:0];
		end
	endfunction : clamp
	function automatic logic [15:0] ms10(input logic [15:0] v);
		ms10 = 16'(v * UNIT10_TICKS[15:0]);
	endfunction : ms10
	function automatic logic powered(input sbs_state_e s);
		powered = (s == ST_RUN) || (s == ST_DELAY) || (s == ST_DIP) || (s == ST_ZSTOP);
	endfunction : powered
	// ==============================================================
	// Declarations
	sbs_tmr_if tif ();
	sbs_state_e  state_q, state_d;
	logic        wr_pend_q;
	logic [7:0]  wr_addr_q;
	logic [31:0] rdata_q;
	logic [1:0]  stop_pend_q, stop_act_q;
	logic        alm_pend_q, alm_act_q;
	logic [15:0] brk_dly_q, brk_spd_q, brk_wait_q, dip_hold_q;
	logic [IRQ_W-1:0] irq_stat_q, irq_en_q, irq_set, irq_clr;
	logic        restart;
	logic        alarm_any, alarm_q, standstill, zero_path;
	logic        brake_q, power_q, db_q, zss_q, ready_q;
	sbs_state_e  alarm_dest;
	logic        addr_ok;

	// ==============================================================
	// Shared time base and timer
	sbs_ms_tick #(
		.CYC (TICK_CYCLES)
	) u_tick (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.tick     (tif.tick)
	);
	sbs_ms_timer u_timer (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.tif      (tif.tmr)
	);
	// ==============================================================
	// AHB-Lite slave: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_q;
	assign addr_ok   = hsel && htrans[1] && hready;
	// Address phase capture for writes
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= addr_ok && hwrite;
			wr_addr_q <= haddr[7:0];
		end
	end
	// Read data prepared in the address phase
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rdata_q <= 32'h0000_0000;
		end else if (addr_ok && !hwrite) begin
			case (haddr[7:0])
				OFS_STOP_CFG: rdata_q <= {27'h0, alm_pend_q, 2'h0, stop_pend_q};
				OFS_BRK_DLY:  rdata_q <= {16'h0000, brk_dly_q};
				OFS_BRK_SPD:  rdata_q <= {16'h0000, brk_spd_q};
				OFS_BRK_WAIT: rdata_q <= {16'h0000, brk_wait_q};
				OFS_DIP_HOLD: rdata_q <= {16'h0000, dip_hold_q};
				OFS_STATUS:   rdata_q <= {22'h0, alm_act_q, stop_act_q, ready_q,
					db_q, power_q, brake_release_out, state_q};
				OFS_IRQ_STAT: rdata_q <= {28'h0, irq_stat_q};
				OFS_IRQ_EN:   rdata_q <= {28'h0, irq_en_q};
				default:      rdata_q <= 32'h0000_0000;
			endcase
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end
	// Timing and threshold settings, effective at once
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			brk_dly_q  <= RST_BRK_DLY;
			brk_spd_q  <= RST_BRK_SPD;
			brk_wait_q <= RST_BRK_WAIT;
			dip_hold_q <= RST_DIP_HOLD;
		end else if (wr_pend_q) begin
			case (wr_addr_q)
				OFS_BRK_DLY:  brk_dly_q  <= clamp(hwdata, 16'h0000, MAX_BRK_DLY);
				OFS_BRK_SPD:  brk_spd_q  <= clamp(hwdata, 16'h0000, MAX_BRK_SPD);
				OFS_BRK_WAIT: brk_wait_q <= clamp(hwdata, MIN_BRK_WAIT, MAX_BRK_WAIT);
				OFS_DIP_HOLD: dip_hold_q <= clamp(hwdata, MIN_DIP_HOLD, MAX_DIP_HOLD);
				default: ;
			endcase
		end
	end
	// Stop selectors: pending copy written, active copy taken at restart
	assign restart = wr_pend_q && wr_addr_q == OFS_CTRL && hwdata[CTRL_RESTART];
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			stop_pend_q <= RST_STOP_SEL;
			alm_pend_q  <= RST_ALM_SEL;
		end else if (wr_pend_q && wr_addr_q == OFS_STOP_CFG) begin
			stop_pend_q <= (hwdata[STOP_SEL_LSB+:2] > STOP_COAST) ? STOP_COAST
				: hwdata[STOP_SEL_LSB+:2];
			alm_pend_q  <= hwdata[ALM_SEL_BIT];
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			stop_act_q <= RST_STOP_SEL;
			alm_act_q  <= RST_ALM_SEL;
		end else if (restart) begin
			stop_act_q <= stop_pend_q;
			alm_act_q  <= alm_pend_q;
		end
	end

	// ==============================================================
	// Interrupts: sticky status, set wins over clear
	assign irq_clr = (wr_pend_q && wr_addr_q == OFS_IRQ_CLR) ? hwdata[IRQ_W-1:0] : '0;
	always_comb begin
		irq_set = '0;
		irq_set[IRQ_ALARM]   = alarm_any && !alarm_q;
		irq_set[IRQ_BRAKE]   = brake_q && !brake_release_out;
		irq_set[IRQ_DIP_OFF] = state_d == ST_DIPOFF && state_q != ST_DIPOFF;
		irq_set[IRQ_RESTORE] = state_q == ST_DIPOFF && state_d != ST_DIPOFF && main_supply_ok;
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
		end
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			irq_en_q <= '0;
		end else if (wr_pend_q && wr_addr_q == OFS_IRQ_EN) begin
			irq_en_q <= hwdata[IRQ_W-1:0];
		end
	end
	assign irq = |(irq_stat_q & irq_en_q);
	// ==============================================================
	// Stop decisions
	assign alarm_any  = first_class_alarm || second_class_alarm;
	assign standstill = motor_speed < brk_spd_q;
	assign zero_path  = second_class_alarm && !alm_act_q;
	// Alarm target: power drops now unless a zero-speed stop is asked while turning
	always_comb begin
		if (zero_path && !standstill) begin
			alarm_dest = ST_ZSTOP;
		end else if (!standstill) begin
			alarm_dest = ST_WAITB;
		end else begin
			alarm_dest = ST_HALT;
		end
	end
	// ==============================================================
	// Sequencer next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_OFF: begin
				if (servo_on && main_supply_ok && control_supply_ok && !alarm_any) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!control_supply_ok) begin
					state_d = standstill ? ST_OFF : ST_WAITB;
				end else if (alarm_any) begin
					state_d = alarm_dest;
				end else if (!servo_on) begin
					state_d = ST_DELAY;
				end else if (!main_supply_ok) begin
					state_d = ST_DIP;
				end
			end
			ST_DELAY: begin
				if (!control_supply_ok) begin
					state_d = standstill ? ST_OFF : ST_WAITB;
				end else if (alarm_any) begin
					state_d = alarm_dest;
				end else if (tif.expired) begin
					state_d = ST_OFF;
				end
			end
			ST_DIP: begin
				if (!control_supply_ok) begin
					state_d = standstill ? ST_OFF : ST_WAITB;
				end else if (alarm_any) begin
					state_d = alarm_dest;
				end else if (main_supply_ok) begin
					state_d = ST_RUN;
				end else if (!servo_on) begin
					state_d = ST_DELAY;
				end else if (tif.expired) begin
					state_d = ST_DIPOFF;
				end
			end
			ST_DIPOFF: begin
				if (alarm_any) begin
					state_d = ST_HALT;
				end else if (main_supply_ok && control_supply_ok) begin
					state_d = servo_on ? ST_RUN : ST_OFF;
				end
			end
			ST_ZSTOP: begin
				if (!control_supply_ok) begin
					state_d = ST_WAITB;
				end else if (standstill || tif.expired) begin
					state_d = ST_HALT;
				end
			end
			ST_WAITB: begin
				if (standstill || tif.expired) begin
					state_d = alarm_any ? ST_HALT : ST_OFF;
				end
			end
			ST_HALT: begin
				if (!alarm_any && !servo_on) begin
					state_d = ST_OFF;
				end
			end
			default: state_d = ST_OFF;
		endcase
		if (restart) begin
			state_d = ST_OFF;
		end
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_q <= ST_OFF;
		end else begin
			state_q <= state_d;
		end
	end
	// Timer load on every state change
	assign tif.load = state_d != state_q;
	always_comb begin
		case (state_d)
			ST_DELAY: tif.load_ms = ms10(brk_dly_q);
			ST_DIP:   tif.load_ms = dip_hold_q;
			ST_ZSTOP: tif.load_ms = ms10(brk_wait_q);
			ST_WAITB: tif.load_ms = ms10(brk_wait_q);
			default:  tif.load_ms = 16'h0000;
		endcase
	end

	// ==============================================================
	// Outputs
	// Brake release drops with the servo-on pin without a cycle of lag in ST_RUN and ST_DIP
	always_comb begin
		brake_release_out = 1'b0;
		case (state_q)
			ST_RUN, ST_DIP: brake_release_out = servo_on && !alarm_any;
			ST_ZSTOP, ST_WAITB: brake_release_out = 1'b1;
			default: brake_release_out = 1'b0;
		endcase
		if (overtravel && servo_on && !alarm_any && state_q != ST_OFF) begin
			brake_release_out = 1'b1;
		end
	end
	// Power, dynamic brake, zero-speed command and ready, from next state
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			power_q <= 1'b0;
			zss_q   <= 1'b0;
		end else begin
			power_q <= powered(state_d);
			zss_q   <= state_d == ST_ZSTOP;
		end
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			db_q <= 1'b0;
		end else if (powered(state_d)) begin
			db_q <= 1'b0;
		end else begin
			case (stop_act_q)
				STOP_DB_HOLD:  db_q <= 1'b1;
				STOP_DB_COAST: db_q <= motor_speed != 16'h0000;
				default:       db_q <= 1'b0;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ready_q <= 1'b0;
			alarm_q <= 1'b0;
			brake_q <= 1'b0;
		end else begin
			ready_q <= control_supply_ok && !alarm_any && state_d != ST_DIPOFF
				&& (main_supply_ok || state_d == ST_DIP);
			alarm_q <= alarm_any;
			brake_q <= brake_release_out;
		end
	end
	assign motor_power_on     = power_q;
	assign dynamic_brake_stop = db_q;
	assign zero_speed_stop    = zss_q;
	assign servo_ready        = ready_q;
endmodule : sbs_seq

// File: verification/sbs_motor_model.sv
// Motor stand-in on the far side of the sequencer.
// Assumes the bench sets commanded speed and run-down per cycle.
`timescale 1ns/1ps
module sbs_motor_model (
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic        motor_power_on,
	input  wire logic        zero_speed_stop,
	input  wire logic [15:0] set_speed,
	input  wire logic [15:0] decel,
	output logic      [15:0] motor_speed
);
	// Speed follows command while driven, else runs down by decel each cycle
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			motor_speed <= 16'h0000;
		end else if (motor_power_on && !zero_speed_stop) begin
			motor_speed <= set_speed;
		end else if (motor_speed > decel) begin
			motor_speed <= motor_speed - decel;
		end else begin
			motor_speed <= 16'h0000;
		end
	end
endmodule : sbs_motor_model

// File: verification/sbs_seq_monitor.sv
// Port checker for the brake and stop sequencer.
// Assumes it is bound into sbs_seq with the same tick length.
`timescale 1ns/1ps
module sbs_seq_monitor #(
	parameter int unsigned TICK_CYCLES = 10
) (
	input wire logic        core_clk,
	input wire logic        sys_rst,
	input wire logic        servo_on,
	input wire logic        first_class_alarm,
	input wire logic        second_class_alarm,
	input wire logic        overtravel,
	input wire logic        main_supply_ok,
	input wire logic        control_supply_ok,
	input wire logic [15:0] motor_speed,
	input wire logic        brake_release_out,
	input wire logic        motor_power_on,
	input wire logic        servo_ready
);
	// ====================
	// Helper logic
	// Longest brake wait is 100 units of 10 ms, plus tick slack
	localparam int unsigned WAIT_LIM = 1000 * TICK_CYCLES + 4;
	wire logic   no_alm;
	logic [31:0] rel_cnt_q;

	// No alarm input active
	assign no_alm = !first_class_alarm && !second_class_alarm;

	// Cycles with brake still released while the motor is unpowered
	always_ff @(posedge core_clk) begin
		if (sys_rst || motor_power_on || !brake_release_out) begin
			rel_cnt_q <= '0;
		end else begin
			rel_cnt_q <= rel_cnt_q + 32'h1;
		end
	end

	// ====================
	// Properties
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	sequence s_dip_start;
		$fell(main_supply_ok) && motor_power_on && servo_on && no_alm;
	endsequence
	sequence s_dip_off;
		$fell(motor_power_on) && !main_supply_ok && control_supply_ok && no_alm;
	endsequence

	property p_brake_at_off;
		$fell(servo_on) && !overtravel |-> !brake_release_out;
	endproperty
	property p_alarm_cut;
		$rose(first_class_alarm) |=> !motor_power_on;
	endproperty
	property p_brake_wait;
		rel_cnt_q <= WAIT_LIM;
	endproperty
	property p_dip_hold;
		s_dip_start |=> motor_power_on [*8];
	endproperty
	property p_dip_drop;
		s_dip_off |-> !servo_ready && !brake_release_out;
	endproperty
	property p_restore;
		$rose(main_supply_ok) && servo_on && control_supply_ok && no_alm && !motor_power_on
			|=> motor_power_on;
	endproperty
	property p_ctrl_loss;
		$fell(control_supply_ok) && no_alm && motor_speed == 16'h0000 |=> !motor_power_on;
	endproperty
	property p_ot_hold;
		overtravel && servo_on && no_alm && motor_power_on |-> brake_release_out;
	endproperty

	a_brake_at_off: assert property (p_brake_at_off)
		else $error("brake still released after servo-off");
	a_alarm_cut: assert property (p_alarm_cut)
		else $error("motor power kept after alarm");
	a_brake_wait: assert property (p_brake_wait)
		else $error("brake not applied within wait limit");
	a_dip_hold: assert property (p_dip_hold)
		else $error("motor power lost early in supply dip");
	a_dip_drop: assert property (p_dip_drop)
		else $error("ready or brake release kept after long dip");
	a_restore: assert property (p_restore)
		else $error("motor power not restored with supply");
	a_ctrl_loss: assert property (p_ctrl_loss)
		else $error("motor power kept after control supply loss");
	a_ot_hold: assert property (p_ot_hold)
		else $error("brake applied during overtravel");
endmodule : sbs_seq_monitor

bind sbs_seq sbs_seq_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
	.core_clk, .sys_rst, .servo_on, .first_class_alarm, .second_class_alarm,
	.overtravel, .main_supply_ok, .control_supply_ok, .motor_speed,
	.brake_release_out, .motor_power_on, .servo_ready
);

// File: verification/test_sbs_seq.sv
// Self-checking bench for the brake and stop sequencer.
// Assumes a 10-cycle tick, so 1 ms here is 10 core clocks.
`timescale 1ns/1ps
module test_sbs_seq
	import sbs_pkg::*;
;
	localparam int unsigned TC = 10;
	logic        core_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic        servo_on = 1'b0;
	logic        first_class_alarm = 1'b0;
	logic        second_class_alarm = 1'b0;
	logic        overtravel = 1'b0;
	logic        main_supply_ok = 1'b1;
	logic        control_supply_ok = 1'b1;
	logic [15:0] set_speed = '0;
	logic [15:0] decel = '0;
	wire logic   hreadyout, brake_release_out, motor_power_on, dynamic_brake_stop;
	wire logic   zero_speed_stop, servo_ready, irq;
	wire logic [31:0] hrdata;
	wire logic [15:0] motor_speed;
	int          errors = 0;
	int          check_count = 0;
	int          n;
	logic [31:0] rd;

	// Core clock, 8 ns period
	always #4 core_clk = ~core_clk;

	sbs_seq #(.TICK_CYCLES(TC)) uut (
		.core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp(), .hrdata, .servo_on, .first_class_alarm,
		.second_class_alarm, .overtravel, .main_supply_ok, .control_supply_ok,
		.motor_speed, .brake_release_out, .motor_power_on, .dynamic_brake_stop,
		.zero_speed_stop, .servo_ready, .irq
	);
	sbs_motor_model u_mot (
		.core_clk, .sys_rst, .motor_power_on, .zero_speed_stop, .set_speed, .decel,
		.motor_speed
	);

	// ====================
	// Tasks
	task give_verdict;
		if (errors == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : give_verdict

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk

	task rdy;
		for (int i = 0; i < 64; i++) begin
			@(posedge core_clk);
			if (hreadyout === 1'b1) return;
		end
		errors++;
		give_verdict();
	endtask : rdy

	// One single AHB-Lite transfer, read data left in rd
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		rdy();
		rd = hrdata;
		#1;
	endtask : bus

	task rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rchk

	task wchk(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		bus(1'b1, a, d);
		rchk(a, e);
	endtask : wchk

	// Wait for power (0), brake release (1) or ready (2) to reach v
	task wt(input int k, input logic v, output int c);
		logic s;
		for (c = 0; c < 20000; c++) begin
			@(posedge core_clk);
			#1;
			s = (k == 0) ? motor_power_on : (k == 1) ? brake_release_out : servo_ready;
			if (s === v) return;
		end
		errors++;
		give_verdict();
	endtask : wt

	task rng(input int lo, input int hi);
		chk({31'h0, n >= lo && n <= hi}, 32'h1);
	endtask : rng

	task up(input logic [15:0] s);
		@(posedge core_clk);
		servo_on <= 1'b1;
		set_speed <= s;
		wt(0, 1'b1, n);
	endtask : up

	task idle;
		@(posedge core_clk);
		first_class_alarm <= 1'b0;
		second_class_alarm <= 1'b0;
		servo_on <= 1'b0;
		control_supply_ok <= 1'b1;
		repeat (2) @(posedge core_clk);
	endtask : idle

	// ====================
	// Main sequence
	initial begin
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'b0;
		rchk(OFS_BRK_DLY, 32'h0000000A);
		chk({31'h0, dynamic_brake_stop}, 32'h1);
		rchk(OFS_BRK_SPD, 32'h00000064);
		rchk(OFS_BRK_WAIT, 32'h00000032);
		rchk(OFS_DIP_HOLD, 32'h00000014);
		rchk(8'h3C, 32'h00000000);
		wchk(OFS_BRK_DLY, 32'h33, 32'h32);
		wchk(OFS_BRK_SPD, 32'h2711, 32'h2710);
		wchk(OFS_BRK_WAIT, 32'h5, 32'h0000000A);
		wchk(OFS_DIP_HOLD, 32'h13, 32'h14);
		wchk(OFS_BRK_SPD, 32'h64, 32'h64);
		wchk(OFS_BRK_DLY, 32'h2, 32'h2);
		// Servo-off at rest under each stop method
		for (int m = 0; m < 3; m++) begin
			bus(1'b1, OFS_STOP_CFG, 32'(m));
			bus(1'b1, OFS_CTRL, 32'h1);
			up(16'h0000);
			@(posedge core_clk);
			servo_on <= 1'b0;
			#1 chk({31'h0, brake_release_out}, 32'h0);
			wt(0, 1'b0, n);
			rng(190, 204);
			chk({31'h0, dynamic_brake_stop}, {31'h0, m == 0});
		end
		bus(1'b1, OFS_STOP_CFG, 32'h0);
		rchk(OFS_STATUS, 32'h00000140);
		chk({30'h0, rd[8:7]}, 32'h2);
		bus(1'b1, OFS_CTRL, 32'h1);
		// First-class alarm while turning, brake on wait timeout
		bus(1'b1, OFS_IRQ_EN, 32'h3);
		up(16'h01F4);
		@(posedge core_clk);
		first_class_alarm <= 1'b1;
		wt(0, 1'b0, n);
		rng(0, 0);
		chk({30'h0, brake_release_out, dynamic_brake_stop}, 32'h3);
		wt(1, 1'b0, n);
		rng(990, 1004);
		chk({31'h0, irq}, 32'h1);
		rchk(OFS_IRQ_STAT, 32'h3);
		bus(1'b1, OFS_IRQ_EN, 32'h0);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, OFS_IRQ_EN, 32'h3);
		bus(1'b1, OFS_IRQ_CLR, 32'h3);
		rchk(OFS_IRQ_STAT, 32'h0);
		chk({31'h0, irq}, 32'h0);
		idle();
		// Second-class alarm: zero-speed stop, brake on speed threshold
		up(16'h012C);
		@(posedge core_clk);
		second_class_alarm <= 1'b1;
		decel <= 16'h0001;
		@(posedge core_clk);
		#1 chk({30'h0, zero_speed_stop, motor_power_on}, 32'h3);
		wt(1, 1'b0, n);
		rng(190, 210);
		chk({31'h0, dynamic_brake_stop}, 32'h1);
		idle();
		// Short and long main-supply dips
		up(16'h0000);
		@(posedge core_clk);
		main_supply_ok <= 1'b0;
		repeat (150) @(posedge core_clk);
		main_supply_ok <= 1'b1;
		#1 chk({30'h0, motor_power_on, servo_ready}, 32'h3);
		@(posedge core_clk);
		main_supply_ok <= 1'b0;
		wt(0, 1'b0, n);
		rng(190, 204);
		chk({30'h0, servo_ready, brake_release_out}, 32'h0);
		@(posedge core_clk);
		overtravel <= 1'b1;
		@(posedge core_clk);
		#1 chk({31'h0, brake_release_out}, 32'h1);
		@(posedge core_clk);
		overtravel <= 1'b0;
		main_supply_ok <= 1'b1;
		wt(0, 1'b1, n);
		rng(0, 1);
		rchk(OFS_IRQ_STAT, 32'h0000000F);
		// Overtravel, then control supply loss at rest
		@(posedge core_clk);
		overtravel <= 1'b1;
		@(posedge core_clk);
		#1 chk({31'h0, brake_release_out}, 32'h1);
		@(posedge core_clk);
		overtravel <= 1'b0;
		control_supply_ok <= 1'b0;
		wt(0, 1'b0, n);
		rng(0, 0);
		idle();
		give_verdict();
	end
endmodule : test_sbs_seq
